// ==== src/fmsp_pkg.sv ====
// shared constants for the fan motor start and protection controller
// assumes a 20 MHz system clock; all times are converted to cycle counts here
package fmsp_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    // times in their printed units
    localparam int unsigned STEP_MS = 50;            // current step period
    localparam int unsigned START_WINDOW_MS = 1000;  // start window
    localparam int unsigned LOCK_DISABLE_MS = 8000;  // lock disable period
    localparam int unsigned RAMP_US_X100 = 1533000;  // 15.33 ms per percent, in 0.01 us
    localparam int unsigned OFF_TIME_US = 24;        // fixed off time
    // derived cycle counts (integer divisions truncate)
    localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);
    localparam int unsigned START_WINDOW_CYC = START_WINDOW_MS * (CLK_HZ / 1000);
    localparam int unsigned LOCK_DISABLE_CYC = LOCK_DISABLE_MS * (CLK_HZ / 1000);
    localparam int unsigned RAMP_CYC_PER_PCT = RAMP_US_X100 / 100 * (CLK_HZ / 1_000_000);
    localparam int unsigned OFF_TIME_CYC = OFF_TIME_US * (CLK_HZ / 1_000_000);
    // 9-bit demand scale: 511 is full scale
    localparam int unsigned DW = 9;
    localparam logic [8:0] DEMAND_FULL = 9'h1_FF;
    localparam logic [8:0] DEMAND_25 = 9'h0_80;      // 25 percent
    localparam logic [8:0] DEMAND_12P5 = 9'h0_40;    // 12.5 percent
    localparam logic [8:0] DEMAND_1PCT = 9'h0_05;    // one percent step of demand
    localparam logic [8:0] DEMAND_ZERO = 9'h0_00;
    // commutation interval counter width and default thresholds
    localparam int unsigned CW = 24;
    localparam logic [23:0] SINE_ENTRY_DEF = 24'h01_0000;
    localparam logic [23:0] ADV_T1_DEF = 24'h00_8000;  // interval for first advance step
    localparam logic [23:0] ADV_T2_DEF = 24'h00_4000;  // interval for second advance step
    localparam logic [23:0] ADV_HYST_DEF = 24'h00_0400; // interval hysteresis band
    localparam logic [7:0] ADV_A1_DEF = 8'h0_A;        // advance angle step one, degrees
    localparam logic [7:0] ADV_A2_DEF = 8'h1_4;        // advance angle step two, degrees
    // current limit levels
    localparam logic [7:0] ILIM_STEP_DEF = 8'h1_0;
    localparam logic [7:0] ILIM_FIXED_DEF = 8'hF_F;
    localparam logic [7:0] ILIM_ZERO = 8'h0_0;
    // states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_START = 5'b00010,
        ST_SINE = 5'b00100,
        ST_LOCK = 5'b01000,
        ST_FAULT = 5'b10000
    } fmsp_state_e;
endpackage

// ==== src/fmsp_ctrl.sv ====
// fan motor start, soft start, lock retry, current limit and short protection control
// assumes digitised demand and comparator flags on clk; hall and select pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module fmsp_ctrl
    import fmsp_pkg::*;
#(
    parameter logic [23:0] SINE_ENTRY = SINE_ENTRY_DEF,
    parameter logic [23:0] ADV_T1 = ADV_T1_DEF,
    parameter logic [23:0] ADV_T2 = ADV_T2_DEF,
    parameter logic [23:0] ADV_HYST = ADV_HYST_DEF,
    parameter logic [7:0] ADV_A1 = ADV_A1_DEF,
    parameter logic [7:0] ADV_A2 = ADV_A2_DEF,
    parameter logic [7:0] ILIM_STEP = ILIM_STEP_DEF,
    parameter logic [7:0] ILIM_FIXED = ILIM_FIXED_DEF,
    parameter int unsigned STEP_CYCLES = STEP_CYC,
    parameter int unsigned START_CYCLES = START_WINDOW_CYC,
    parameter int unsigned LOCK_CYCLES = LOCK_DISABLE_CYC,
    parameter int unsigned RAMP_CYCLES = RAMP_CYC_PER_PCT,
    parameter int unsigned OFF_CYCLES = OFF_TIME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [8:0] speed_demand_input,
    input wire logic hall_a_state,
    input wire logic hall_b_state,
    input wire logic hall_c_state,
    input wire logic phase_advance_select,
    input wire logic overcurrent,
    input wire logic short_detect,
    output logic speed_indicator_output,
    output logic sine_mode,
    output logic phase_output_enable,
    output logic source_off,
    output logic [8:0] drive_demand,
    output logic [7:0] current_limit_level,
    output logic [7:0] phase_advance_deg,
    output logic [23:0] commutation_interval
);
    // decoding used by several processes: is demand strictly above a level
    function automatic logic above(input logic [8:0] v, input logic [8:0] lvl);
        return v > lvl;
    endfunction

    // two-flop synchronisers for the asynchronous pins
    logic [3:0] pin_meta_q, pin_sync_q, pin_prev_q;
    logic [1:0] pin_age_q; // cycles since reset, saturating
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
            pin_age_q <= 2'h0;
        end else begin
            pin_meta_q <= {phase_advance_select, hall_c_state, hall_b_state, hall_a_state};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
            pin_age_q <= (pin_age_q == 2'h3) ? pin_age_q : pin_age_q + 2'h1;
        end
    end
    // the flops leave reset at zero, not at the real hall code, so a change seen
    // before the previous-sample flop holds a synced value is not a commutation
    logic comm_edge;
    assign comm_edge = (pin_age_q == 2'h3) && (pin_sync_q[2:0] != pin_prev_q[2:0]);

    // demand mapping: zero at or below 12.5 percent, value kept above
    logic [8:0] ext_demand;
    always_comb begin
        ext_demand = above(speed_demand_input, DEMAND_12P5) ? speed_demand_input : DEMAND_ZERO;
    end

    // commutation interval measurement
    logic [23:0] comm_cnt_q, comm_cnt_d, comm_int_q, comm_int_d;
    always_comb begin
        comm_cnt_d = (comm_cnt_q == 24'hFF_FFFF) ? comm_cnt_q : comm_cnt_q + 24'h00_0001;
        comm_int_d = comm_int_q;
        if (comm_edge) begin
            comm_int_d = comm_cnt_q;
            // the edge cycle counts as one, so the interval equals the edge spacing
            comm_cnt_d = 24'h00_0001;
        end else if (comm_cnt_q > comm_int_q) begin
            comm_int_d = comm_cnt_q; // a stalled rotor shows as a growing interval
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            comm_cnt_q <= 24'h00_0000;
            comm_int_q <= 24'hFF_FFFF;
        end else begin
            comm_cnt_q <= comm_cnt_d;
            comm_int_q <= comm_int_d;
        end
    end
    logic interval_ok;
    assign interval_ok = comm_int_q < SINE_ENTRY;

    // main control state machine with timers and soft start
    fmsp_state_e state_q, state_d;
    logic [27:0] tmr_q, tmr_d;
    logic [21:0] step_q, step_d;
    logic [19:0] ramp_q, ramp_d;
    logic [8:0] dem_q, dem_d;
    logic [7:0] ilim_q, ilim_d;
    logic [8:0] prev_dem_q;
    logic oe_q, oe_d, sine_q, sine_d;
    // a drop straight to zero from a running demand skips the ramp
    logic fast_zero;
    assign fast_zero = (ext_demand == DEMAND_ZERO) && above(prev_dem_q, DEMAND_25);
    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q + 28'h000_0001;
        step_d = step_q;
        ramp_d = ramp_q;
        dem_d = dem_q;
        ilim_d = ilim_q;
        oe_d = oe_q;
        sine_d = sine_q;
        case (state_q)
            ST_IDLE: begin
                oe_d = 1'b0;
                sine_d = 1'b0;
                ilim_d = ILIM_ZERO;
                if (above(ext_demand, DEMAND_25)) begin
                    state_d = ST_START;
                    tmr_d = 28'h000_0000;
                    step_d = 22'h00_0000;
                    oe_d = 1'b1;
                    dem_d = DEMAND_FULL;
                end
            end
            ST_START: begin
                sine_d = 1'b0;
                dem_d = DEMAND_FULL;
                if (step_q == 22'(STEP_CYCLES - 1)) begin
                    step_d = 22'h00_0000;
                    if (ilim_q <= 8'(8'hFF - ILIM_STEP)) begin
                        ilim_d = ilim_q + ILIM_STEP;
                    end
                end else begin
                    step_d = step_q + 22'h00_0001;
                end
                if (interval_ok && comm_edge) begin
                    state_d = ST_SINE;
                    sine_d = 1'b1;
                    ilim_d = ILIM_FIXED;
                    dem_d = DEMAND_25;
                    ramp_d = 20'h0_0000;
                end else if (tmr_q >= 28'(START_CYCLES - 1)) begin
                    state_d = ST_LOCK;
                    oe_d = 1'b0;
                    tmr_d = 28'h000_0000;
                end
            end
            ST_SINE: begin
                // soft start toward the external setting
                if (ramp_q == 20'(RAMP_CYCLES - 1)) begin
                    ramp_d = 20'h0_0000;
                    // ten-bit compares so a step near full scale cannot wrap
                    if (10'(dem_q) + 10'(DEMAND_1PCT) <= 10'(ext_demand)) begin
                        dem_d = dem_q + DEMAND_1PCT;
                    end else if (10'(dem_q) >= 10'(ext_demand) + 10'(DEMAND_1PCT)) begin
                        dem_d = dem_q - DEMAND_1PCT;
                    end else begin
                        dem_d = ext_demand;
                    end
                end else begin
                    ramp_d = ramp_q + 20'h0_0001;
                end
                if (!interval_ok) begin
                    state_d = ST_START;
                    sine_d = 1'b0;
                    dem_d = DEMAND_FULL;
                    ilim_d = ILIM_ZERO;
                    tmr_d = 28'h000_0000;
                    step_d = 22'h00_0000;
                end else if (ext_demand == DEMAND_ZERO) begin
                    state_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            end
            ST_LOCK: begin
                oe_d = 1'b0;
                ilim_d = ILIM_ZERO;
                if (!above(ext_demand, DEMAND_12P5)) begin
                    state_d = ST_IDLE;
                end else if (tmr_q >= 28'(LOCK_CYCLES - 1)) begin
                    state_d = ST_START;
                    oe_d = 1'b1;
                    dem_d = DEMAND_FULL;
                    tmr_d = 28'h000_0000;
                    step_d = 22'h00_0000;
                end
            end
            ST_FAULT: begin
                oe_d = 1'b0;
                sine_d = 1'b0;
                ilim_d = ILIM_ZERO;
                if (!above(ext_demand, DEMAND_12P5)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                oe_d = 1'b0;
            end
        endcase
        // protection overrides everything else
        if (short_detect && (state_q != ST_FAULT)) begin
            state_d = ST_FAULT;
            oe_d = 1'b0;
            sine_d = 1'b0;
        end else if (fast_zero && (state_q != ST_FAULT)) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            sine_d = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            tmr_q <= 28'h000_0000;
            step_q <= 22'h00_0000;
            ramp_q <= 20'h0_0000;
            dem_q <= DEMAND_ZERO;
            ilim_q <= ILIM_ZERO;
            oe_q <= 1'b0;
            sine_q <= 1'b0;
            prev_dem_q <= DEMAND_ZERO;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            step_q <= step_d;
            ramp_q <= ramp_d;
            dem_q <= dem_d;
            ilim_q <= ilim_d;
            oe_q <= oe_d;
            sine_q <= sine_d;
            prev_dem_q <= ext_demand;
        end
    end

    // fixed off-time after a high-side overcurrent
    logic [9:0] off_q, off_d;
    always_comb begin
        off_d = off_q;
        if (off_q != 10'h000) begin
            off_d = off_q - 10'h001;
        end else if (overcurrent && oe_q) begin
            off_d = 10'(OFF_CYCLES);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            off_q <= 10'h000;
        end else begin
            off_q <= off_d;
        end
    end

    // speed dependent phase advance with hysteresis on the interval thresholds
    logic [1:0] adv_q, adv_d;
    always_comb begin
        adv_d = adv_q;
        case (adv_q)
            2'd0: if (comm_int_q < ADV_T1 - ADV_HYST) adv_d = 2'd1;
            2'd1: begin
                if (comm_int_q > ADV_T1 + ADV_HYST) begin
                    adv_d = 2'd0;
                end else if (comm_int_q < ADV_T2 - ADV_HYST) begin
                    adv_d = 2'd2;
                end
            end
            2'd2: if (comm_int_q > ADV_T2 + ADV_HYST) adv_d = 2'd1;
            default: adv_d = 2'd0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            adv_q <= 2'd0;
        end else begin
            adv_q <= adv_d;
        end
    end

    // advance angle: none outside sine mode or while the select pin is low
    logic [7:0] adv_deg_d;
    always_comb begin
        adv_deg_d = 8'h0_0;
        if (pin_sync_q[3] && sine_q) begin
            case (adv_q)
                2'd1: adv_deg_d = ADV_A1;
                2'd2: adv_deg_d = ADV_A2;
                default: adv_deg_d = 8'h0_0;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            speed_indicator_output <= 1'b0;
            sine_mode <= 1'b0;
            phase_output_enable <= 1'b0;
            source_off <= 1'b0;
            drive_demand <= DEMAND_ZERO;
            current_limit_level <= ILIM_ZERO;
            phase_advance_deg <= 8'h0_0;
            commutation_interval <= 24'hFF_FFFF;
        end else begin
            speed_indicator_output <= pin_sync_q[0];
            sine_mode <= sine_q;
            phase_output_enable <= oe_q;
            source_off <= off_q != 10'h000;
            drive_demand <= dem_q;
            current_limit_level <= ilim_q;
            commutation_interval <= comm_int_q;
            phase_advance_deg <= adv_deg_d;
        end
    end
endmodule
`default_nettype wire

// ==== bench/fmsp_ctrl_asserts.sv ====
// port checker for the fan motor start and protection controller
// assumes it is bound into fmsp_ctrl and inherits its shortened counts
`timescale 1ns/1ps
`default_nettype none
module fmsp_ctrl_asserts
    import fmsp_pkg::*;
#(
    parameter logic [23:0] SINE_ENTRY = SINE_ENTRY_DEF,
    parameter logic [7:0] ILIM_FIXED = ILIM_FIXED_DEF,
    parameter int unsigned RAMP_CYCLES = RAMP_CYC_PER_PCT,
    parameter int unsigned OFF_CYCLES = OFF_TIME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [8:0] speed_demand_input,
    input wire logic hall_a_state,
    input wire logic phase_advance_select,
    input wire logic overcurrent,
    input wire logic short_detect,
    input wire logic speed_indicator_output,
    input wire logic sine_mode,
    input wire logic phase_output_enable,
    input wire logic source_off,
    input wire logic [8:0] drive_demand,
    input wire logic [7:0] current_limit_level,
    input wire logic [7:0] phase_advance_deg,
    input wire logic [23:0] commutation_interval
);
    logic [2:0] up_q;
    logic [8:0] dem_q;
    int unsigned off_q;
    int unsigned hold_q;
    // cycles since reset, length of the off pulse, cycles the demand has held
    always_ff @(posedge clk) begin
        up_q <= rst ? 3'h0 : ((up_q == 3'h7) ? up_q : up_q + 3'h1);
        off_q <= (rst || !source_off) ? 0 : off_q + 1;
        hold_q <= (rst || drive_demand != dem_q) ? 0 : hold_q + 1;
        dem_q <= drive_demand;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_oc_seen;
        overcurrent && phase_output_enable && !source_off && !short_detect
            && speed_demand_input != DEMAND_ZERO;
    endsequence
    sequence s_fast_drop;
        speed_demand_input == DEMAND_ZERO && $past(speed_demand_input) > DEMAND_25;
    endsequence
    a_fg_copy: assert property (up_q >= 3'h4 |-> speed_indicator_output == $past(hall_a_state, 3))
        else $error("speed indicator does not follow hall a");
    a_start_full: assert property ($rose(phase_output_enable) |-> !sine_mode && drive_demand == DEMAND_FULL)
        else $error("start not trapezoidal at full demand");
    a_sine_entry: assert property ($rose(sine_mode) |-> drive_demand == DEMAND_25)
        else $error("sine entry demand wrong");
    a_sine_limit: assert property (sine_mode |-> current_limit_level == ILIM_FIXED)
        else $error("limit not fixed in sine mode");
    a_ramp_pace: assert property (sine_mode && $past(sine_mode) && drive_demand != dem_q
        |-> hold_q >= RAMP_CYCLES - 1 && (drive_demand - dem_q <= DEMAND_1PCT
        || dem_q - drive_demand <= DEMAND_1PCT)) else $error("demand ramp too fast");
    a_off_start: assert property (s_oc_seen |-> ##[1:2] source_off)
        else $error("overcurrent did not switch source off");
    a_off_len: assert property ($fell(source_off) |-> off_q == OFF_CYCLES)
        else $error("off time length wrong");
    a_fast_stop: assert property (s_fast_drop |-> ##[1:2] !phase_output_enable)
        else $error("fast drop did not disable bridges");
    a_short_off: assert property (short_detect |-> ##[1:2] !phase_output_enable)
        else $error("short did not disable outputs");
    a_adv_none: assert property ((!phase_advance_select)[*4] |-> ##1 phase_advance_deg == 8'h00)
        else $error("advance applied while deselected");
    a_sine_exit: assert property (sine_mode && commutation_interval >= SINE_ENTRY |-> ##[0:2] !sine_mode)
        else $error("slow interval kept sine mode");
endmodule
bind fmsp_ctrl fmsp_ctrl_asserts #(
    .SINE_ENTRY(SINE_ENTRY), .ILIM_FIXED(ILIM_FIXED), .RAMP_CYCLES(RAMP_CYCLES),
    .OFF_CYCLES(OFF_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .speed_demand_input(speed_demand_input),
    .hall_a_state(hall_a_state), .phase_advance_select(phase_advance_select),
    .overcurrent(overcurrent), .short_detect(short_detect),
    .speed_indicator_output(speed_indicator_output), .sine_mode(sine_mode),
    .phase_output_enable(phase_output_enable), .source_off(source_off),
    .drive_demand(drive_demand), .current_limit_level(current_limit_level),
    .phase_advance_deg(phase_advance_deg), .commutation_interval(commutation_interval)
);
`default_nettype wire

// ==== bench/fmsp_motor_model.sv ====
// behavioural three-phase fan motor with hall sensors
// assumes the rotor turns only while driven; a zero step count means locked
`timescale 1ns/1ps
`default_nettype none
module fmsp_motor_model (
    input wire logic clk,
    input wire logic drive_en,
    input wire logic [7:0] step_cycles,
    output logic hall_a,
    output logic hall_b,
    output logic hall_c
);
    logic [2:0] pos_q = 3'h0;
    logic [7:0] cnt_q = 8'h00;
    // one hall state per step period; a coasting rotor is treated as stopped
    always @(negedge clk) begin
        if (drive_en && step_cycles != 8'h00) begin
            cnt_q <= (cnt_q + 8'h01 >= step_cycles) ? 8'h00 : cnt_q + 8'h01;
            if (cnt_q + 8'h01 >= step_cycles) begin
                pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
            end
        end
    end
    // 120 degree spaced sensors, six states per electrical turn
    assign hall_a = pos_q <= 3'h2;
    assign hall_b = pos_q >= 3'h2 && pos_q <= 3'h4;
    assign hall_c = pos_q >= 3'h4 || pos_q == 3'h0;
endmodule
`default_nettype wire

// ==== bench/fmsp_ctrl_tb.sv ====
// self-checking bench for the fan motor start and protection controller
// assumes shortened counts below; the motor model makes the hall signals
`timescale 1ns/1ps
`default_nettype none
module fmsp_ctrl_tb;
    import fmsp_pkg::*;
    localparam int STEP_C = 20;
    localparam int START_C = 200;
    localparam int LOCK_C = 300;
    localparam int RAMP_C = 4;
    localparam int OFF_C = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] dem = 9'h0_00;
    logic adv_sel = 1'b1;
    logic oc = 1'b0;
    logic sh = 1'b0;
    logic [7:0] motor_step = 8'h00;
    wire logic ha, hb, hc;
    logic sine, en, soff;
    logic [8:0] dd, tgt;
    logic [7:0] lim, adv;
    logic [23:0] ci;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 4135;
    int n;
    fmsp_ctrl #(
        .SINE_ENTRY(24'h00_0040), .ADV_T1(24'h00_0030), .ADV_T2(24'h00_0018),
        .ADV_HYST(24'h00_0004), .STEP_CYCLES(STEP_C), .START_CYCLES(START_C),
        .LOCK_CYCLES(LOCK_C), .RAMP_CYCLES(RAMP_C), .OFF_CYCLES(OFF_C)
    ) u_dut (
        .clk(clk), .rst(rst), .speed_demand_input(dem), .hall_a_state(ha),
        .hall_b_state(hb), .hall_c_state(hc), .phase_advance_select(adv_sel),
        .overcurrent(oc), .short_detect(sh), .speed_indicator_output(),
        .sine_mode(sine), .phase_output_enable(en), .source_off(soff),
        .drive_demand(dd), .current_limit_level(lim), .phase_advance_deg(adv),
        .commutation_interval(ci)
    );
    fmsp_motor_model u_motor (.clk(clk), .drive_en(en), .step_cycles(motor_step),
        .hall_a(ha), .hall_b(hb), .hall_c(hc));
    // clock and a cycle ceiling that cuts a hang short
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            close_out();
        end
    end
    // demand after the dead zone: at or below 12.5 percent means zero
    function automatic logic [8:0] exp_dem(input logic [8:0] d);
        return (d <= DEMAND_12P5) ? DEMAND_ZERO : d;
    endfunction
    // cycles for the ramp to cover a change, one percent step per ramp period
    function automatic int ramp_wait(input logic [8:0] a, input logic [8:0] b);
        int diff;
        diff = (a > b) ? int'(a - b) : int'(b - a);
        return ((diff + 4) / int'(DEMAND_1PCT) + 2) * RAMP_C;
    endfunction
    task automatic chk1(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chkv(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait at falling edges for enable (sel 0) or sine mode (sel 1) to reach val
    task automatic wait_sig(input int sel, input logic val, input int lim_c);
        int k;
        k = 0;
        while (((sel == 0) ? en : sine) !== val && k < lim_c) begin
            @(negedge clk);
            k++;
        end
        chk1("wait level", val, (sel == 0) ? en : sine);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        chkv("interval at reset", 24'hFF_FFFF, ci);
        // start, sine entry, ramps, advance, off time and fast stop
        for (int i = 0; i < 3; i++) begin
            tgt = (i == 0) ? DEMAND_FULL : 9'h0_C0 + (9'($random(seed)) & 9'h1_3F);
            motor_step = 8'h08 + (8'($random(seed)) & 8'h07);
            dem = tgt;
            wait_sig(0, 1'b1, 4);
            chkv("start demand", 24'(DEMAND_FULL), 24'(dd));
            wait_sig(1, 1'b1, 8 * motor_step);
            chkv("sine demand", 24'(DEMAND_25), 24'(dd));
            chkv("sine limit", 24'(ILIM_FIXED_DEF), 24'(lim));
            repeat (ramp_wait(DEMAND_25, tgt)) @(negedge clk);
            chkv("ramp up", 24'(exp_dem(tgt)), 24'(dd));
            // several steady commutations have passed, so the interval is one step
            chkv("interval", 24'(motor_step), ci);
            chkv("advance", 24'(ADV_A2_DEF), 24'(adv));
            adv_sel = 1'b0;
            repeat (5) @(negedge clk);
            chkv("no advance", 24'h00_0000, 24'(adv));
            adv_sel = 1'b1;
            oc = 1'b1;
            @(negedge clk);
            oc = 1'b0;
            n = 0;
            repeat (12) begin
                @(negedge clk);
                n += int'(soff);
            end
            chkv("off time", 24'(OFF_C), 24'(n));
            dem = 9'h0_A0;
            repeat (ramp_wait(tgt, 9'h0_A0)) @(negedge clk);
            chkv("ramp down", 24'h00_00A0, 24'(dd));
            dem = DEMAND_ZERO;
            repeat (3) @(negedge clk);
            chk1("fast stop", 1'b0, en);
            $display("run %0d done", i);
        end
        // stall in sine, restart with stepped limit, lock and retry
        dem = 9'h1_00;
        motor_step = 8'h0A;
        wait_sig(1, 1'b1, 200);
        motor_step = 8'h00;
        wait_sig(1, 1'b0, 100);
        chkv("restart demand", 24'(DEMAND_FULL), 24'(dd));
        chkv("start limit", 24'(ILIM_ZERO), 24'(lim));
        repeat (STEP_C) @(negedge clk);
        chkv("limit step", 24'(ILIM_STEP_DEF), 24'(lim));
        wait_sig(0, 1'b0, START_C + 10);
        n = 0;
        while (en === 1'b0 && n < LOCK_C + 50) begin
            @(negedge clk);
            n++;
        end
        chk1("lock span", 1'b1, n >= LOCK_C - 3 && n <= LOCK_C + 3);
        // a demand between 12.5 and 25 percent keeps the retries going
        dem = 9'h0_60;
        wait_sig(0, 1'b0, START_C + 10);
        wait_sig(0, 1'b1, LOCK_C + 10);
        dem = 9'h0_30;
        repeat (START_C + LOCK_C + 50) @(negedge clk);
        chk1("no retry", 1'b0, en);
        $display("lock test done");
        // short shutdown, restart by lowering then raising demand
        dem = 9'h1_00;
        motor_step = 8'h0A;
        wait_sig(0, 1'b1, 4);
        sh = 1'b1;
        @(negedge clk);
        sh = 1'b0;
        repeat (40) @(negedge clk);
        chk1("short coast", 1'b0, en);
        dem = 9'h0_20;
        repeat (3) @(negedge clk);
        dem = 9'h1_00;
        wait_sig(0, 1'b1, 4);
        sh = 1'b1;
        repeat (3) @(negedge clk);
        chk1("short again", 1'b0, en);
        sh = 1'b0;
        dem = DEMAND_ZERO;
        $display("short test done");
        close_out();
    end
endmodule
`default_nettype wire
